// *** design/dsof_status_flags.sv ***
`timescale 1ns/1ps
`include "dsof_consts.svh"
module dsof_status_flags
   import dsof_pkg::*;
(
   // clock and reset
   input wire logic i_ref_clk,
   input wire logic i_rst_n,
   // drive quantities, same clock domain
   input wire dsof_pkg::dsof_freq_t i_out_freq,
   input wire dsof_pkg::dsof_freq_t i_cmd_freq,
   input wire dsof_pkg::dsof_freq_t i_max_freq,
   input wire dsof_pkg::dsof_freq_t i_motor_speed,
   input wire dsof_pkg::dsof_ramp_t i_ramp,
   input wire logic i_running,
   input wire logic i_dc_braking,
   input wire logic i_fault,
   input wire logic i_sensor_vector,
   input wire logic [31:0] i_run_hours,
   input wire logic [31:0] i_power_hours,
   // settings
   input wire dsof_pkg::dsof_freq_t i_accel_arrival_threshold_a,
   input wire dsof_pkg::dsof_freq_t i_decel_arrival_threshold_a,
   input wire dsof_pkg::dsof_freq_t i_accel_arrival_threshold_b,
   input wire dsof_pkg::dsof_freq_t i_decel_arrival_threshold_b,
   input wire logic [15:0] i_hours_warning_limit,
   input wire logic i_warn_coarse,
   input wire dsof_pkg::dsof_freq_t i_zero_speed_level,
   input wire dsof_pkg::dsof_pol_t i_fault_relay_polarity,
   input wire dsof_pkg::dsof_fn_t i_terminal_function_select [`DSOF_NUM_TERM],
   input wire dsof_pkg::dsof_pol_t i_terminal_polarity_select [`DSOF_NUM_TERM],
   input wire dsof_pkg::dsof_fn_t i_relay_function_select,
   // flags
   output logic o_run_flag,
   output logic o_const_speed_reached,
   output logic o_overreach_flag_a,
   output logic o_set_reached_flag_a,
   output logic o_overreach_flag_b,
   output logic o_set_reached_flag_b,
   output logic o_run_hours_over,
   output logic o_power_hours_over,
   output logic o_zero_speed_flag,
   // terminals
   output logic [`DSOF_NUM_TERM-1:0] o_terminal,
   output logic o_relay_contact_one,
   output logic o_relay_contact_two
);
   import dsof_pkg::*;

   // -----------------------------------------
   // reset release
   // -----------------------------------------
   logic rst_s1_q;
   logic rst_s2_q;
   logic rst_n;
   always_ff @(posedge i_ref_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         rst_s1_q <= 1'b0;
         rst_s2_q <= 1'b0;
      end
      else
      begin
         rst_s1_q <= 1'b1;
         rst_s2_q <= rst_s1_q;
      end
   end
   assign rst_n = rst_s2_q;

   // -----------------------------------------
   // helpers
   // -----------------------------------------
   function automatic logic [16:0] pct_of(input dsof_freq_t f, input logic [7:0] p);
      logic [31:0] prod;
      prod = ({16'h0000, f} * {24'h000000, p}) / `DSOF_PCT_DIV;
      return prod[16:0];
   endfunction : pct_of

   function automatic logic [17:0] ext(input dsof_freq_t f);
      return {2'b00, f};
   endfunction : ext

   function automatic logic clamp_on(input dsof_freq_t f, input dsof_freq_t lim);
      return (f != 16'h0000) && (f <= lim);
   endfunction : clamp_on

   logic [17:0] on_band;
   logic [17:0] off_band;
   logic [17:0] fo;
   assign on_band = {1'b0, pct_of(i_max_freq, `DSOF_ON_PCT)};
   assign off_band = {1'b0, pct_of(i_max_freq, `DSOF_OFF_PCT)};
   assign fo = ext(i_out_freq);

   // -----------------------------------------
   // frequency arrival
   // -----------------------------------------
   logic decel;
   dsof_freq_t thr_a;
   dsof_freq_t thr_b;
   logic en_a;
   logic en_b;
   assign decel = (i_ramp == DSOF_RAMP_DECEL);
   assign thr_a = decel ? i_decel_arrival_threshold_a : i_accel_arrival_threshold_a;
   assign thr_b = decel ? i_decel_arrival_threshold_b : i_accel_arrival_threshold_b;
   assign en_a = clamp_on(thr_a, `DSOF_ARRIVAL_MAX);
   assign en_b = clamp_on(thr_b, `DSOF_ARRIVAL_MAX);

   // on: f+on_band >= t ; off: f+off_band < t
   logic const_set;
   logic const_clr;
   assign const_set = (fo + on_band) >= ext(i_cmd_freq);
   assign const_clr = (fo + off_band) < ext(i_cmd_freq);

   dsof_hyst_flag u_const
   (
      .i_ref_clk(i_ref_clk),
      .i_rst_n(rst_n),
      .i_enable(i_running && (i_cmd_freq != 16'h0000)),
      .i_set_cond(const_set),
      .i_clr_cond(const_clr),
      .o_flag(o_const_speed_reached)
   );

   dsof_hyst_flag u_over_a
   (
      .i_ref_clk(i_ref_clk),
      .i_rst_n(rst_n),
      .i_enable(en_a),
      .i_set_cond((fo + on_band) >= ext(thr_a)),
      .i_clr_cond((fo + off_band) < ext(thr_a)),
      .o_flag(o_overreach_flag_a)
   );

   dsof_hyst_flag u_over_b
   (
      .i_ref_clk(i_ref_clk),
      .i_rst_n(rst_n),
      .i_enable(en_b),
      .i_set_cond((fo + on_band) >= ext(thr_b)),
      .i_clr_cond((fo + off_band) < ext(thr_b)),
      .o_flag(o_overreach_flag_b)
   );

   // set-reached: window depends on ramp direction
   logic sr_set_a;
   logic sr_clr_a;
   logic sr_set_b;
   logic sr_clr_b;
   always_comb
   begin
      if (decel)
      begin
         sr_set_a = fo <= (ext(thr_a) + on_band);
         sr_clr_a = (fo + off_band) < ext(thr_a);
         sr_set_b = fo <= (ext(thr_b) + on_band);
         sr_clr_b = (fo + off_band) < ext(thr_b);
      end
      else
      begin
         // falling under target-2% also clears, so the flag never lingers far below target
         sr_set_a = ((fo + on_band) >= ext(thr_a)) && (fo <= ext(thr_a) + off_band);
         sr_clr_a = (fo > (ext(thr_a) + off_band)) || ((fo + off_band) < ext(thr_a));
         sr_set_b = ((fo + on_band) >= ext(thr_b)) && (fo <= ext(thr_b) + off_band);
         sr_clr_b = (fo > (ext(thr_b) + off_band)) || ((fo + off_band) < ext(thr_b));
      end
   end

   dsof_hyst_flag u_set_a
   (
      .i_ref_clk(i_ref_clk),
      .i_rst_n(rst_n),
      .i_enable(en_a),
      .i_set_cond(sr_set_a && !sr_clr_a),
      .i_clr_cond(sr_clr_a),
      .o_flag(o_set_reached_flag_a)
   );

   dsof_hyst_flag u_set_b
   (
      .i_ref_clk(i_ref_clk),
      .i_rst_n(rst_n),
      .i_enable(en_b),
      .i_set_cond(sr_set_b && !sr_clr_b),
      .i_clr_cond(sr_clr_b),
      .o_flag(o_set_reached_flag_b)
   );

   // -----------------------------------------
   // run, hours, zero speed
   // -----------------------------------------
   logic [31:0] warn_hours;
   logic warn_en;
   dsof_freq_t zs_src;
   dsof_freq_t zs_lvl;
   logic run_d;
   logic run_q;
   logic run_hrs_d;
   logic run_hrs_q;
   logic pwr_hrs_d;
   logic pwr_hrs_q;
   logic zero_d;
   logic zero_q;

   always_comb
   begin
      warn_en = (i_hours_warning_limit != 16'h0000);
      if (i_warn_coarse)
      begin
         warn_hours = {16'h0000, i_hours_warning_limit} * `DSOF_WARN_UNIT_COARSE;
      end
      else
      begin
         warn_hours = {16'h0000, i_hours_warning_limit} * `DSOF_WARN_UNIT_FINE;
      end
      zs_src = i_sensor_vector ? i_motor_speed : i_out_freq;
      zs_lvl = (i_zero_speed_level > `DSOF_ZERO_LEVEL_MAX) ? `DSOF_ZERO_LEVEL_MAX : i_zero_speed_level;
      run_d = i_running || i_dc_braking;
      run_hrs_d = warn_en && (i_run_hours > warn_hours);
      pwr_hrs_d = warn_en && (i_power_hours > warn_hours);
      zero_d = zs_src < zs_lvl;
   end

   always_ff @(posedge i_ref_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         run_q <= 1'b0;
         run_hrs_q <= 1'b0;
         pwr_hrs_q <= 1'b0;
         zero_q <= 1'b0;
      end
      else
      begin
         run_q <= run_d;
         run_hrs_q <= run_hrs_d;
         pwr_hrs_q <= pwr_hrs_d;
         zero_q <= zero_d;
      end
   end

   assign o_run_flag = run_q;
   assign o_run_hours_over = run_hrs_q;
   assign o_power_hours_over = pwr_hrs_q;
   assign o_zero_speed_flag = zero_q;

   // -----------------------------------------
   // terminal assignment
   // -----------------------------------------
   function automatic logic pick(input dsof_fn_t code);
      logic r;
      r = 1'b0;
      unique case (code)
         `DSOF_FN_RUN: r = run_q;
         `DSOF_FN_CONST: r = o_const_speed_reached;
         `DSOF_FN_OVER_A: r = o_overreach_flag_a;
         `DSOF_FN_SET_A: r = o_set_reached_flag_a;
         `DSOF_FN_OVER_B: r = o_overreach_flag_b;
         `DSOF_FN_SET_B: r = o_set_reached_flag_b;
         `DSOF_FN_RUN_HRS: r = run_hrs_q;
         `DSOF_FN_PWR_HRS: r = pwr_hrs_q;
         `DSOF_FN_ZERO: r = zero_q;
         default: r = 1'b0;
      endcase
      return r;
   endfunction : pick

   logic [`DSOF_NUM_TERM-1:0] term_d;
   logic [`DSOF_NUM_TERM-1:0] term_q;
   logic relay_sig;
   logic relay_d;
   logic relay_q;

   always_comb
   begin
      for (int i = 0; i < `DSOF_NUM_TERM; i++)
      begin
         term_d[i] = pick(i_terminal_function_select[i]) ^
                     (i_terminal_polarity_select[i] == `DSOF_POL_NC);
      end
      relay_sig = i_fault || pick(i_relay_function_select);
      // relay_d high means contact one to common closed
      relay_d = (i_fault_relay_polarity == `DSOF_POL_NO) ? relay_sig : !relay_sig;
   end

   always_ff @(posedge i_ref_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         term_q <= '0;
         relay_q <= 1'b0;
      end
      else
      begin
         term_q <= term_d;
         relay_q <= relay_d;
      end
   end

   assign o_terminal = term_q;
   assign o_relay_contact_one = relay_q;
   assign o_relay_contact_two = !relay_q;

   // -----------------------------------------
   // checks
   // -----------------------------------------
   property p_relay_pol;
      @(posedge i_ref_clk) disable iff (!rst_n)
      (i_fault && i_fault_relay_polarity == `DSOF_POL_NC) |=> !o_relay_contact_one;
   endproperty
   a_relay_pol: assert property (p_relay_pol) else $error("relay open expected on fault");

   property p_run;
      @(posedge i_ref_clk) disable iff (!rst_n)
      i_dc_braking |=> o_run_flag;
   endproperty
   a_run: assert property (p_run) else $error("run flag missing during braking");

   property p_disable_a;
      @(posedge i_ref_clk) disable iff (!rst_n)
      (thr_a == 16'h0000) |=> !o_overreach_flag_a && !o_set_reached_flag_a;
   endproperty
   a_disable_a: assert property (p_disable_a) else $error("arrival a active while disabled");

   property p_over_hold;
      @(posedge i_ref_clk) disable iff (!rst_n)
      (en_a && $stable(thr_a) && !((fo + on_band) >= ext(thr_a)) && !((fo + off_band) < ext(thr_a)))
         |=> $stable(o_overreach_flag_a);
   endproperty
   a_over_hold: assert property (p_over_hold) else $error("overreach changed inside band");

   property p_over_clr;
      @(posedge i_ref_clk) disable iff (!rst_n)
      ((fo + off_band) < ext(thr_a)) && !((fo + on_band) >= ext(thr_a)) |=> !o_overreach_flag_a;
   endproperty
   a_over_clr: assert property (p_over_clr) else $error("overreach not cleared");

   property p_hours;
      @(posedge i_ref_clk) disable iff (!rst_n)
      (i_hours_warning_limit == 16'h0000) |=> !o_run_hours_over && !o_power_hours_over;
   endproperty
   a_hours: assert property (p_hours) else $error("hours flag with warning disabled");

   property p_zero_src;
      @(posedge i_ref_clk) disable iff (!rst_n)
      (i_sensor_vector && i_motor_speed < zs_lvl) |=> o_zero_speed_flag;
   endproperty
   a_zero_src: assert property (p_zero_src) else $error("zero speed missed");

   property p_term_pol;
      @(posedge i_ref_clk) disable iff (!rst_n)
      (i_terminal_function_select[1] == `DSOF_FN_CONST && i_terminal_polarity_select[1] == `DSOF_POL_NC)
         |=> (o_terminal[1] != $past(o_const_speed_reached));
   endproperty
   a_term_pol: assert property (p_term_pol) else $error("terminal polarity wrong");

   c_const: cover property (@(posedge i_ref_clk) disable iff (!rst_n) $rose(o_const_speed_reached));
   c_set_a: cover property (@(posedge i_ref_clk) disable iff (!rst_n) $fell(o_set_reached_flag_a));
   c_zero: cover property (@(posedge i_ref_clk) disable iff (!rst_n) $rose(o_zero_speed_flag));
   c_hours: cover property (@(posedge i_ref_clk) disable iff (!rst_n) $rose(o_run_hours_over));
endmodule : dsof_status_flags

// *** design/dsof_consts.svh ***
`ifndef DSOF_CONSTS_SVH
`define DSOF_CONSTS_SVH
// frequencies in units of 0.01 Hz, 16 bits
`define DSOF_FREQ_W 16
// largest threshold and zero-speed level setting
`define DSOF_ARRIVAL_MAX 16'd40000
`define DSOF_ZERO_LEVEL_MAX 16'd10000
// hysteresis as hundredths of maximum frequency
`define DSOF_ON_PCT 8'd1
`define DSOF_OFF_PCT 8'd2
`define DSOF_PCT_DIV 32'd100
// function codes for terminals
`define DSOF_FN_RUN 6'h00
`define DSOF_FN_CONST 6'h01
`define DSOF_FN_OVER_A 6'h02
`define DSOF_FN_SET_A 6'h06
`define DSOF_FN_RUN_HRS 6'h0b
`define DSOF_FN_PWR_HRS 6'h0c
`define DSOF_FN_ZERO 6'h15
`define DSOF_FN_OVER_B 6'h18
`define DSOF_FN_SET_B 6'h19
// warning time decode
`define DSOF_WARN_FINE_MAX 16'd9999
`define DSOF_WARN_UNIT_FINE 32'd10
`define DSOF_WARN_UNIT_COARSE 32'd100
// polarity codes
`define DSOF_POL_NO 2'h0
`define DSOF_POL_NC 2'h1
// number of transistor terminals
`define DSOF_NUM_TERM 5
`endif

// *** design/dsof_pkg.sv ***
package dsof_pkg;
   typedef logic [15:0] dsof_freq_t;
   typedef logic [5:0] dsof_fn_t;
   typedef logic [1:0] dsof_pol_t;
   typedef enum logic [1:0]
   {
      DSOF_RAMP_STEADY = 2'b00,
      DSOF_RAMP_ACCEL = 2'b01,
      DSOF_RAMP_DECEL = 2'b10
   } dsof_ramp_t;
endpackage : dsof_pkg

// *** design/dsof_hyst_flag.sv ***
`timescale 1ns/1ps
`include "dsof_consts.svh"
// one hysteretic comparator: on at or above on level, off below off level
module dsof_hyst_flag
(
   // clock and reset
   input wire logic i_ref_clk,
   input wire logic i_rst_n,
   // compare
   input wire logic i_enable,
   input wire logic i_set_cond,
   input wire logic i_clr_cond,
   // result
   output logic o_flag
);
   logic flag_q;
   logic flag_d;

   always_comb
   begin
      flag_d = flag_q;
      if (!i_enable)
      begin
         flag_d = 1'b0;
      end
      else if (i_set_cond)
      begin
         flag_d = 1'b1;
      end
      else if (i_clr_cond)
      begin
         flag_d = 1'b0;
      end
   end

   always_ff @(posedge i_ref_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         flag_q <= 1'b0;
      end
      else
      begin
         flag_q <= flag_d;
      end
   end

   assign o_flag = flag_q;
endmodule : dsof_hyst_flag

// *** tb/dsof_term_reader.sv ***
`timescale 1ns/1ps
// far-side wiring: the controller reading the five terminals and the relay
module dsof_term_reader
(
   // from the drive
   input wire logic [4:0] i_terminal,
   input wire logic i_relay_contact_one,
   input wire logic i_relay_contact_two,
   // what the controller sees
   output logic [6:0] o_seen
);
   // a changeover contact: one and two are read as separate circuits
   assign o_seen = {i_terminal, i_relay_contact_one, i_relay_contact_two};
endmodule : dsof_term_reader

// *** tb/testbench.sv ***
`timescale 1ns/1ps
`include "dsof_consts.svh"
`define CHK(got, exp) \
   begin \
      n_tests++; \
      if ((got) !== (exp)) \
      begin \
         fail_count++; \
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp); \
      end \
   end
module testbench;
   import dsof_pkg::*;
   typedef struct {int unsigned due; logic [15:0] mask; logic [15:0] val;} dsof_note_t;
   // -----------------------------
   // signals
   // -----------------------------
   logic ref_clk = 1'b0;
   logic rst_n = 1'b0;
   dsof_freq_t out_freq, cmd_freq, max_freq, motor_speed, zero_level;
   dsof_freq_t thr [4];
   dsof_ramp_t ramp;
   logic running, dc_braking, fault, sensor_vector, warn_coarse;
   logic [31:0] run_hours, power_hours;
   logic [15:0] warn_limit, rnd, m;
   dsof_pol_t relay_pol;
   dsof_fn_t fn_sel [`DSOF_NUM_TERM];
   dsof_pol_t pol_sel [`DSOF_NUM_TERM];
   dsof_fn_t relay_fn;
   logic run_flag, const_flag, over_a, set_a, over_b, set_b, run_hrs, pwr_hrs, zero_flag;
   logic [4:0] terminal;
   logic relay_one, relay_two;
   logic [6:0] seen;
   logic [15:0] obs;
   int unsigned cyc = 0;
   int fail_count = 0;
   int n_tests = 0;
   dsof_note_t notes [$];
   localparam logic [15:0] M_RUN = 16'h8000, M_CONST = 16'h4000, M_RHRS = 16'h0200, M_PHRS = 16'h0100;
   localparam logic [15:0] M_ZERO = 16'h0080;
   localparam logic [31:0] RUN_H [5] = '{32'h32, 32'h33, 32'h33, 32'h1f5, 32'hffffffff};
   localparam logic [31:0] PWR_H [5] = '{32'h33, 32'h33, 32'h33, 32'h1f4, 32'hffffffff};
   localparam logic [15:0] HRS_M [5] = '{16'h0120, 16'h0330, 16'h0000, 16'h0210, 16'h0000};
   assign obs = {run_flag, const_flag, over_a, set_a, over_b, set_b, run_hrs, pwr_hrs, zero_flag, seen};
   // -----------------------------
   // design and far side
   // -----------------------------
   dsof_status_flags i_dut (.i_ref_clk(ref_clk), .i_rst_n(rst_n), .i_out_freq(out_freq),
      .i_cmd_freq(cmd_freq), .i_max_freq(max_freq), .i_motor_speed(motor_speed), .i_ramp(ramp),
      .i_running(running), .i_dc_braking(dc_braking), .i_fault(fault), .i_sensor_vector(sensor_vector),
      .i_run_hours(run_hours), .i_power_hours(power_hours), .i_accel_arrival_threshold_a(thr[0]),
      .i_decel_arrival_threshold_a(thr[1]), .i_accel_arrival_threshold_b(thr[2]),
      .i_decel_arrival_threshold_b(thr[3]), .i_hours_warning_limit(warn_limit),
      .i_warn_coarse(warn_coarse), .i_zero_speed_level(zero_level), .i_fault_relay_polarity(relay_pol),
      .i_terminal_function_select(fn_sel), .i_terminal_polarity_select(pol_sel),
      .i_relay_function_select(relay_fn), .o_run_flag(run_flag), .o_const_speed_reached(const_flag),
      .o_overreach_flag_a(over_a), .o_set_reached_flag_a(set_a), .o_overreach_flag_b(over_b),
      .o_set_reached_flag_b(set_b), .o_run_hours_over(run_hrs), .o_power_hours_over(pwr_hrs),
      .o_zero_speed_flag(zero_flag), .o_terminal(terminal), .o_relay_contact_one(relay_one),
      .o_relay_contact_two(relay_two));
   dsof_term_reader i_reader (.i_terminal(terminal), .i_relay_contact_one(relay_one),
      .i_relay_contact_two(relay_two), .o_seen(seen));
   // -----------------------------
   // clock, timeout, monitor
   // -----------------------------
   always #10 ref_clk = ~ref_clk;
   always @(posedge ref_clk)
   begin
      cyc++;
      if (cyc > 1000)
      begin
         fail_count++;
         results();
      end
   end
   always @(negedge ref_clk)
   begin
      while (notes.size() > 0 && notes[0].due <= cyc)
      begin
         `CHK(obs & notes[0].mask, notes[0].val & notes[0].mask)
         void'(notes.pop_front());
      end
   end
   // -----------------------------
   // tasks
   // -----------------------------
   function automatic logic [15:0] lfsr(input logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction : lfsr
   // note an expectation three cycles on, covering flag and terminal latency
   task automatic expect_out(input logic [15:0] mask, input logic [15:0] val);
      notes.push_back('{cyc + 3, mask, val});
      repeat (3) @(negedge ref_clk);
   endtask : expect_out
   task automatic results;
      $display("comparisons %0d mismatches %0d", n_tests, fail_count);
      if (fail_count == 0 && n_tests > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask : results
   // -----------------------------
   // stimulus
   // -----------------------------
   initial
   begin
      out_freq = 16'h0000; cmd_freq = 16'h0000; max_freq = 16'h2710; motor_speed = 16'h0000;
      zero_level = 16'h0000; thr = '{16'h0000, 16'h0000, 16'h0000, 16'h0000}; ramp = DSOF_RAMP_STEADY;
      running = 1'b0; dc_braking = 1'b0; fault = 1'b0; sensor_vector = 1'b0; warn_coarse = 1'b0;
      run_hours = 32'h00000000; power_hours = 32'h00000000; warn_limit = 16'h0000; rnd = 16'h05c2;
      relay_pol = 2'h1; relay_fn = 6'h3f;
      fn_sel = '{6'h00, 6'h01, 6'h0b, 6'h0c, 6'h15};
      pol_sel = '{2'h0, 2'h1, 2'h0, 2'h0, 2'h0};
      repeat (2) @(negedge ref_clk);
      expect_out(16'hffff, 16'h0001);
      rst_n = 1'b1;
      repeat (4) @(negedge ref_clk);
      expect_out(16'hffff, 16'h000a);
      running = 1'b1;
      expect_out(M_RUN | 16'h0004, M_RUN | 16'h0004);
      running = 1'b0;
      dc_braking = 1'b1;
      expect_out(M_RUN | 16'h0004, M_RUN | 16'h0004);
      dc_braking = 1'b0;
      expect_out(M_RUN | 16'h0004, 16'h0000);
      for (int p = 0; p < 2; p++)
      begin
         for (int f = 0; f < 2; f++)
         begin
            relay_pol = 2'(p);
            fault = 1'(f);
            m = ((p == 0) == (f == 1)) ? 16'h0002 : 16'h0001;
            expect_out(16'h0003, m);
         end
      end
      fault = 1'b0;
      relay_pol = 2'h1;
      running = 1'b1;
      cmd_freq = 16'h0bb8;
      out_freq = 16'h0b53;
      expect_out(M_CONST | 16'h0008, 16'h0008);
      out_freq = 16'h0b54;
      expect_out(M_CONST | 16'h0008, M_CONST);
      for (int p = 0; p < 2; p++)
      begin
         thr[2 * p] = 16'h1388;
         thr[2 * p + 1] = 16'h1770;
         m = (p == 0) ? 16'h2000 : 16'h0800;
         ramp = DSOF_RAMP_ACCEL;
         out_freq = 16'h1323;
         expect_out(m, 16'h0000);
         out_freq = 16'h1324;
         expect_out(m | (m >> 1), m | (m >> 1));
         out_freq = 16'h12c1;
         expect_out(m, m);
         out_freq = 16'h12bf;
         expect_out(m | (m >> 1), 16'h0000);
         out_freq = 16'h12f2;
         expect_out(m, 16'h0000);
         out_freq = 16'h1450;
         expect_out(m | (m >> 1), m | (m >> 1));
         out_freq = 16'h1451;
         expect_out(m | (m >> 1), m);
         ramp = DSOF_RAMP_DECEL;
         out_freq = 16'h1839;
         expect_out(m >> 1, 16'h0000);
         out_freq = 16'h17d4;
         expect_out(m >> 1, m >> 1);
         out_freq = 16'h16a8;
         expect_out(m >> 1, m >> 1);
         out_freq = 16'h16a7;
         expect_out(m >> 1, 16'h0000);
         thr[2 * p] = 16'h0000;
         thr[2 * p + 1] = 16'h0000;
         ramp = DSOF_RAMP_ACCEL;
         out_freq = 16'h1388;
         expect_out(m | (m >> 1), 16'h0000);
      end
      for (int k = 0; k < 5; k++)
      begin
         warn_limit = (k == 4) ? 16'h0000 : 16'h0005;
         warn_coarse = (k == 2 || k == 3);
         run_hours = RUN_H[k];
         power_hours = PWR_H[k];
         m = HRS_M[k];
         expect_out(M_RHRS | M_PHRS | 16'h0030, m);
      end
      zero_level = 16'h03e8;
      for (int k = 0; k < 40; k++)
      begin
         rnd = lfsr(rnd);
         out_freq = {6'h00, rnd[9:0]};
         motor_speed = {6'h00, rnd[15:6]};
         sensor_vector = rnd[3];
         m = ((rnd[3] ? motor_speed : out_freq) < 16'h03e8) ? 16'h00c0 : 16'h0000;
         expect_out(M_ZERO | 16'h0040, m);
      end
      zero_level = 16'h2710;
      sensor_vector = 1'b0;
      out_freq = 16'h270f;
      expect_out(M_ZERO | 16'h0040, 16'h00c0);
      // let the monitor take the last note before the verdict
      @(negedge ref_clk);
      results();
   end
endmodule : testbench
